/* hdl/uss_pkg.sv */
// Purpose: Shared constants and types for the USB supply switch control block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Offsets are byte addresses
package uss_pkg;

    localparam logic [3:0] STRAP_BOOST_DEFAULT = 4'h4;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] ID_OFS = 8'h10;

    // Control register fields
    localparam int CTRL_SRC_SEL_BIT = 0;
    localparam int CTRL_HOST_DRV_BIT = 1;
    localparam int CTRL_LDO_EN_BIT = 2;
    localparam int CTRL_BOOST_EN_BIT = 3;
    localparam int CTRL_ACC_MUX_LSB = 4;

    // Interrupt status fields
    localparam int IRQ_BUS_DET_BIT = 0;
    localparam int IRQ_ACC_BIT = 1;
    localparam int IRQ_WIDTH = 2;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RST = 2'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {ST_RESET, ST_POWERUP, ST_RUN} uss_state_t;

    typedef struct packed {
        logic bus_feed;
        logic boost_feed;
        logic bus_drive;
    } uss_switch_t;

endpackage

/* hdl/uss_top.sv */
// Purpose: Supply path switch control for the USB PHY regulator and OTG bus drive
// Assumes: Single 200 MHz clock, synchronous active-high reset, AXI4-Lite registers
// Notes: Strap sampled in the power-up step after reset release
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module uss_top
(
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    input wire logic [3:0] STRAP_I,
    input wire logic BUS_VALID_I,
    input wire logic SYS_RESET_VALID_I,
    input wire logic ACC_DONE_I,
    input wire logic [3:0] ACC_MUX_I,
    input wire logic [4:0] ID_LEVEL_I,
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic BUS_FEED_SW_O,
    output logic BOOST_FEED_SW_O,
    output logic BUS_DRIVE_SW_O,
    output logic PHY_LDO_ON_O,
    output logic BOOST_EN_O,
    output logic [3:0] ACC_MUX_O,
    output logic IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    uss_pkg::uss_state_t state_q;
    logic boost_strap_q;
    logic src_sel_q;
    logic host_drv_q;
    logic ldo_en_q;
    logic boost_en_q;
    logic [3:0] acc_mux_q;
    logic [4:0] id_level_q;
    logic [uss_pkg::IRQ_WIDTH-1:0] irq_stat_q;
    logic [uss_pkg::IRQ_WIDTH-1:0] irq_mask_q;
    logic bus_valid_q;
    logic sys_rst_valid_q;
    logic otg_drive_q;
    uss_pkg::uss_switch_t sw_q;
    logic ldo_on_q;
    logic irq_q;

    // AXI bookkeeping
    logic aw_held_q;
    logic [7:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    // Take only while ready is shown, so a master never sees a silent double take
    wire aw_take = AWVALID_I && AWREADY_O;
    wire w_take = WVALID_I && WREADY_O;
    wire have_aw = aw_held_q || aw_take;
    wire have_w = w_held_q || w_take;
    wire [7:0] wr_addr = aw_held_q ? aw_addr_q : AWADDR_I;
    wire [31:0] wr_data = w_held_q ? w_data_q : WDATA_I;
    wire [3:0] wr_strb = w_held_q ? w_strb_q : WSTRB_I;
    wire wr_go = have_aw && have_w && !bvalid_q;
    wire wr_lane0 = wr_go && wr_strb[0];
    wire wr_ctrl = wr_lane0 && (wr_addr == uss_pkg::CTRL_OFS);
    wire wr_stat = wr_lane0 && (wr_addr == uss_pkg::IRQ_STAT_OFS);
    wire wr_mask = wr_lane0 && (wr_addr == uss_pkg::IRQ_MASK_OFS);
    wire wr_known = (wr_addr == uss_pkg::CTRL_OFS) || (wr_addr == uss_pkg::STAT_OFS) ||
        (wr_addr == uss_pkg::IRQ_STAT_OFS) || (wr_addr == uss_pkg::IRQ_MASK_OFS) ||
        (wr_addr == uss_pkg::ID_OFS);
    wire rd_take = ARVALID_I && ARREADY_O;

    wire [31:0] ctrl_word = {24'h000000, acc_mux_q, boost_en_q, ldo_en_q, host_drv_q, src_sel_q};
    wire [31:0] stat_word = {24'h000000, 1'b0, bus_valid_q, otg_drive_q, ldo_on_q,
        sw_q.bus_drive, sw_q.boost_feed, sw_q.bus_feed, boost_strap_q};
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (ARADDR_I == uss_pkg::CTRL_OFS)
            rd_word = ctrl_word;
        else if (ARADDR_I == uss_pkg::STAT_OFS)
            rd_word = stat_word;
        else if (ARADDR_I == uss_pkg::IRQ_STAT_OFS)
            rd_word = {30'h00000000, irq_stat_q};
        else if (ARADDR_I == uss_pkg::IRQ_MASK_OFS)
            rd_word = {30'h00000000, irq_mask_q};
        else if (ARADDR_I == uss_pkg::ID_OFS)
            rd_word = {27'h0000000, id_level_q};
        else
            rd_ok = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supply behaviour
    // Invalid combination 1/0 falls out of the AND: bus drive stays open
    wire otg_mode = host_drv_q && src_sel_q;
    wire bus_lost = bus_valid_q && !BUS_VALID_I;
    wire rst_rise = SYS_RESET_VALID_I && !sys_rst_valid_q;
    // Regulator may run off boost only when boost feed chosen; else bus must be valid
    wire ldo_allowed = src_sel_q || BUS_VALID_I;
    wire bus_det_evt = otg_mode && !otg_drive_q;
    wire acc_evt = ACC_DONE_I;
    wire [uss_pkg::IRQ_WIDTH-1:0] irq_set = {acc_evt, bus_det_evt};

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            state_q <= uss_pkg::ST_RESET;
            boost_strap_q <= 1'b0;
            src_sel_q <= 1'b0;
            host_drv_q <= 1'b0;
            ldo_en_q <= 1'b0;
            boost_en_q <= 1'b0;
            acc_mux_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                uss_pkg::ST_RESET:
                    state_q <= uss_pkg::ST_POWERUP;
                uss_pkg::ST_POWERUP:
                begin
                    // Strap caught after reset release, never under reset
                    boost_strap_q <= (STRAP_I == uss_pkg::STRAP_BOOST_DEFAULT);
                    src_sel_q <= (STRAP_I == uss_pkg::STRAP_BOOST_DEFAULT);
                    ldo_en_q <= 1'b1;
                    state_q <= uss_pkg::ST_RUN;
                end
                default:
                begin
                    if (wr_ctrl)
                    begin
                        src_sel_q <= wr_data[uss_pkg::CTRL_SRC_SEL_BIT];
                        host_drv_q <= wr_data[uss_pkg::CTRL_HOST_DRV_BIT];
                        ldo_en_q <= wr_data[uss_pkg::CTRL_LDO_EN_BIT];
                        boost_en_q <= wr_data[uss_pkg::CTRL_BOOST_EN_BIT];
                    end
                    // Hardware restore beats a same-cycle software disable
                    if (!boost_strap_q && (rst_rise || bus_lost))
                        ldo_en_q <= 1'b1;
                    if (acc_evt)
                        acc_mux_q <= ACC_MUX_I;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            bus_valid_q <= 1'b0;
            sys_rst_valid_q <= 1'b0;
            otg_drive_q <= 1'b0;
            sw_q <= '0;
            ldo_on_q <= 1'b0;
            id_level_q <= 5'h00;
        end
        else
        begin
            bus_valid_q <= BUS_VALID_I;
            sys_rst_valid_q <= SYS_RESET_VALID_I;
            otg_drive_q <= otg_mode;
            sw_q.bus_feed <= !src_sel_q;
            sw_q.boost_feed <= src_sel_q;
            sw_q.bus_drive <= otg_mode;
            // Late bus arrival turns it on with no software step
            ldo_on_q <= ldo_en_q && ldo_allowed && (state_q == uss_pkg::ST_RUN);
            id_level_q <= ID_LEVEL_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supply checks, one edge after the cause since outputs are registered
    AST_BUS_FEED_SEL: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        !SRST_I |=> (BUS_FEED_SW_O == !$past(src_sel_q)))
        else $error("Bus feed switch does not follow source select");

    AST_BOOST_FEED_SEL: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        !SRST_I |=> (BOOST_FEED_SW_O == $past(src_sel_q)))
        else $error("Boost feed switch does not follow source select");

    AST_OTG_DRIVE: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        !SRST_I |=> (BUS_DRIVE_SW_O == ($past(host_drv_q) && $past(src_sel_q))))
        else $error("Bus drive switch differs from OTG mode");

    AST_INVALID_NO_DRIVE: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (!SRST_I && host_drv_q && !src_sel_q) |=> !BUS_DRIVE_SW_O)
        else $error("Bus drive switch closed in the invalid combination");

    AST_BOOST_SW_ONLY: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (!SRST_I && !wr_ctrl) |=> $stable(BOOST_EN_O))
        else $error("Boost enable changed without a control write");

    AST_LDO_NEEDS_BUS: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (!SRST_I && !boost_strap_q && !src_sel_q && !BUS_VALID_I) |=> !PHY_LDO_ON_O)
        else $error("Regulator on from bus feed without bus supply");

    AST_LDO_RESTORE: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (!SRST_I && (state_q == uss_pkg::ST_RUN) && !boost_strap_q && (rst_rise || bus_lost)) |=> ldo_en_q)
        else $error("Regulator enable bit not restored");

    AST_POWERUP_DEFAULT: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (!SRST_I && (state_q == uss_pkg::ST_POWERUP)) |=>
        (ldo_en_q && (src_sel_q == ($past(STRAP_I) == uss_pkg::STRAP_BOOST_DEFAULT))))
        else $error("Power-up defaults do not follow the strap");

    AST_BUS_DET_SET: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        (!SRST_I && otg_mode && !otg_drive_q) |=> irq_stat_q[uss_pkg::IRQ_BUS_DET_BIT])
        else $error("Bus power detect event not raised on OTG entry");

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over write-one-to-clear
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= uss_pkg::IRQ_MASK_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? wr_data[uss_pkg::IRQ_WIDTH-1:0] : 2'h0)) | irq_set;
            if (wr_mask)
                irq_mask_q <= wr_data[uss_pkg::IRQ_WIDTH-1:0];
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    AST_IRQ_LEVEL: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        !SRST_I |=> (IRQ_O == |($past(irq_stat_q) & $past(irq_mask_q))))
        else $error("Interrupt level differs from masked status");

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= uss_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= uss_pkg::RESP_OKAY;
        end
        else
        begin
            if (wr_go)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? uss_pkg::RESP_OKAY : uss_pkg::RESP_SLVERR;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= AWADDR_I;
                end
                if (w_take)
                begin
                    w_held_q <= 1'b1;
                    w_data_q <= WDATA_I;
                    w_strb_q <= WSTRB_I;
                end
                if (bvalid_q && BREADY_I)
                    bvalid_q <= 1'b0;
            end
            if (rd_take)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_ok ? uss_pkg::RESP_OKAY : uss_pkg::RESP_SLVERR;
            end
            else if (rvalid_q && RREADY_I)
                rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            AWREADY_O <= 1'b0;
            WREADY_O <= 1'b0;
            ARREADY_O <= 1'b0;
        end
        else
        begin
            // Ready offered one cycle ahead; cleared while a response waits
            AWREADY_O <= !aw_held_q && !aw_take && !bvalid_q && !wr_go;
            WREADY_O <= !w_held_q && !w_take && !bvalid_q && !wr_go;
            ARREADY_O <= !rvalid_q && !rd_take;
        end
    end

    assign BVALID_O = bvalid_q;
    assign BRESP_O = bresp_q;
    assign RVALID_O = rvalid_q;
    assign RDATA_O = rdata_q;
    assign RRESP_O = rresp_q;
    assign BUS_FEED_SW_O = sw_q.bus_feed;
    assign BOOST_FEED_SW_O = sw_q.boost_feed;
    assign BUS_DRIVE_SW_O = sw_q.bus_drive;
    assign PHY_LDO_ON_O = ldo_on_q;
    assign BOOST_EN_O = boost_en_q;
    assign ACC_MUX_O = acc_mux_q;
    assign IRQ_O = irq_q;

endmodule // uss_top

/* testbench/uss_bus_host.sv */
// Purpose: Cable host model that drives the bus supply valid level
// Assumes: Attach level comes from the bench
// Notes: Valid lags attach by a debounce, drops at once on detach
`timescale 1ns/1ps
module uss_bus_host
#(
    parameter int RISE_CYC = 4
)
(
    input wire logic clk_i,
    input wire logic attach_i,
    output logic bus_valid_o
);
    ////////////////////////////////////////
    int cnt_q;
    // Fast fall, slow rise, as a real supply detector
    always_ff @(posedge clk_i)
    begin
        if (!attach_i)
            cnt_q <= 0;
        else if (cnt_q < RISE_CYC)
            cnt_q <= cnt_q + 1;
    end
    assign bus_valid_o = (cnt_q == RISE_CYC);
endmodule // uss_bus_host

/* testbench/uss_top_tb.sv */
// Purpose: Self-checking bench for the supply switch control
// Assumes: AXI4-Lite master tasks, host model on bus supply
// Notes: Settle waits follow the registered outputs
`timescale 1ns/1ps
module uss_top_tb;
    logic clk, srst, attach, bus_valid, sys_rv, acc_done;
    logic [3:0] strap, acc_mux, wstrb, acc_mux_o;
    logic [4:0] id_level;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_q;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [1:0] bresp, rresp, resp_q;
    logic bus_feed, boost_feed, bus_drive, ldo_on, boost_en;
    int bad_count = 0;
    int samples_checked = 0;
    ////////////////////////////////////////
    uss_bus_host u_uss_bus_host (.clk_i(clk), .attach_i(attach), .bus_valid_o(bus_valid));
    uss_top u_uss_top (.REF_CLK_I(clk), .SRST_I(srst), .STRAP_I(strap), .BUS_VALID_I(bus_valid),
        .SYS_RESET_VALID_I(sys_rv), .ACC_DONE_I(acc_done), .ACC_MUX_I(acc_mux), .ID_LEVEL_I(id_level),
        .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
        .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
        .RVALID_O(rvalid), .RREADY_I(rready), .BUS_FEED_SW_O(bus_feed), .BOOST_FEED_SW_O(boost_feed),
        .BUS_DRIVE_SW_O(bus_drive), .PHY_LDO_ON_O(ldo_on), .BOOST_EN_O(boost_en), .ACC_MUX_O(acc_mux_o),
        .IRQ_O(irq));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Valid held until its own ready, bready until bvalid
    task wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, uss_pkg::RESP_OKAY);
        repeat (3) @(posedge clk);
    endtask
    task rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task do_reset(input logic [3:0] s, input logic att);
        strap <= s;
        attach <= att;
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    ////////////////////////////////////////
    task t_cold_bus;
        do_reset(4'h0, 1'b1);
        chk({bus_feed, boost_feed, bus_drive, ldo_on}, 4'b1001);
        rd(uss_pkg::CTRL_OFS);
        chk(rd_q, 32'h4);
    endtask
    task t_modes;
        for (int i = 0; i < 4; i++)
        begin
            wr(uss_pkg::CTRL_OFS, 32'(4 + i));
            chk({bus_feed, boost_feed, bus_drive, boost_en}, {!i[0], i[0], i[0] & i[1], 1'b0});
        end
        wr(uss_pkg::CTRL_OFS, 32'hC);
        chk({bus_feed, boost_en}, 2'b11);
    endtask
    // Bus absent, so only the boost path can power the regulator
    task t_otg_irq;
        attach <= 1'b0;
        repeat (4) @(posedge clk);
        wr(uss_pkg::CTRL_OFS, 32'h0);
        wr(uss_pkg::IRQ_STAT_OFS, 32'h3);
        wr(uss_pkg::CTRL_OFS, 32'h3);
        chk({ldo_on, irq}, 2'b00);
        rd(uss_pkg::IRQ_STAT_OFS);
        chk(rd_q, 32'h1);
        // Event is set, yet bus valid stays clear: it is not host power
        rd(uss_pkg::STAT_OFS);
        chk(rd_q, 32'h2C);
        wr(uss_pkg::IRQ_MASK_OFS, 32'h1);
        chk(irq, 1'b1);
        wr(uss_pkg::CTRL_OFS, 32'h7);
        chk(ldo_on, 1'b1);
        wr(uss_pkg::IRQ_STAT_OFS, 32'h1);
        chk(irq, 1'b0);
    endtask
    task t_restore;
        wr(uss_pkg::CTRL_OFS, 32'h4);
        attach <= 1'b1;
        repeat (10) @(posedge clk);
        wr(uss_pkg::CTRL_OFS, 32'h0);
        chk(ldo_on, 1'b0);
        attach <= 1'b0;
        repeat (3) @(posedge clk);
        rd(uss_pkg::CTRL_OFS);
        chk(rd_q, 32'h4);
        chk(ldo_on, 1'b0);
        attach <= 1'b1;
        repeat (10) @(posedge clk);
        chk(ldo_on, 1'b1);
        wr(uss_pkg::CTRL_OFS, 32'h0);
        chk(ldo_on, 1'b0);
        sys_rv <= 1'b0;
        @(posedge clk);
        sys_rv <= 1'b1;
        repeat (4) @(posedge clk);
        chk(ldo_on, 1'b1);
    endtask
    task t_acc_misc;
        wr(uss_pkg::IRQ_MASK_OFS, 32'h2);
        acc_mux <= 4'h9;
        acc_done <= 1'b1;
        @(posedge clk);
        acc_done <= 1'b0;
        repeat (4) @(posedge clk);
        chk({acc_mux_o, irq}, 5'h13);
        rd(uss_pkg::CTRL_OFS);
        chk(rd_q, 32'h94);
        rd(uss_pkg::ID_OFS);
        chk(rd_q, 32'h13);
        rd(8'h20);
        chk(resp_q, uss_pkg::RESP_SLVERR);
    endtask
    task t_strap4;
        do_reset(4'h4, 1'b0);
        chk({bus_feed, boost_feed, bus_drive, ldo_on}, 4'b0101);
        rd(uss_pkg::STAT_OFS);
        chk(rd_q, 32'h15);
    endtask
    task end_of_test;
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        {srst, attach, sys_rv, acc_done} = 4'b1010;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {strap, acc_mux, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        id_level = 5'h13;
        @(posedge clk);
        t_cold_bus();
        t_modes();
        t_otg_irq();
        t_restore();
        t_acc_misc();
        t_strap4();
        end_of_test();
    end
    // Whole run is under two hundred cycles
    initial
    begin
        #100000;
        bad_count++;
        end_of_test();
    end
endmodule // uss_top_tb
